// ---- design/charger_serial_slave.sv ----
/*
  Two-wire serial slave of the charger with its status and control
  registers, fault queue, watchdog and transaction hang-up timer.
  Assumes the bus master drives the clock without stretching and
  that the analog status inputs are asynchronous levels.
*/
`timescale 1ns/1ps
module charger_serial_slave
  import charger_pkg::*;
#(
  parameter logic [31:0] WATCHDOG_CYC = WATCHDOG_CYCLES,
  parameter logic [31:0] HANGUP_CYC = HANGUP_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // serial link
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // charger status
  input wire logic [1:0] charge_state,
  input wire logic [3:0] fault_code,
  input wire logic internal_regulator_low,
  input wire logic input_undervoltage_lockout,
  // charger control
  output logic [2:0] input_current_limit_select,
  output logic status_output_enable,
  output logic termination_enable,
  output logic charge_disable,
  output logic high_impedance_standby,
  output logic host_mode,
  output logic watchdog_expired_flag
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_ADDR_ACK = 3'b011,
    S_WR = 3'b010,
    S_WR_ACK = 3'b110,
    S_RD = 3'b111,
    S_RD_ACK = 3'b101,
    S_SKIP = 3'b100
  } st_t;

  typedef struct packed {
    logic scl_p;
    logic sda_p;
    st_t st;
    logic [2:0] cnt;
    logic last;
    logic [7:0] shift;
    logic rw;
    logic nack;
    logic first;
    logic [7:0] ptr;
    logic [31:0] hang;
    logic [31:0] wd;
    logic dog_en;
    logic wd_flag;
    logic host;
    logic [6:0] ctrl;
    logic sda_oe;
    logic sda_o;
    logic lockout_seen;
    logic [3:0] live_p;
  } state_t;

  state_t q, d;
  logic scl_s, sda_s, reg_low_s, lockout_s;
  logic [1:0] stat_s;
  logic [3:0] fault_s;
  logic [3:0] live;
  logic [3:0] fq_head;
  logic fq_empty;
  logic push, pop, load, wr_done;
  logic rise, fall, start, stop, hang_hit, wd_hit;
  logic [7:0] rd_byte;

  function automatic logic addr_match(input logic [7:0] b);
    return b[7:1] == DEV_ADDR;
  endfunction

  // all pin levels pass two flops
  sync2 #(.W(10)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d({scl, sda_in, charge_state, fault_code,
        internal_regulator_low, input_undervoltage_lockout}),
    .q({scl_s, sda_s, stat_s, fault_s, reg_low_s, lockout_s})
  );

  fault_queue u_fq (
    .clk(clk),
    .rstn(rstn),
    .push(push),
    .push_code(live),
    .pop(pop),
    .head(fq_head),
    .empty(fq_empty)
  );

  always_comb begin
    d = q;
    load = 1'b0;
    wr_done = 1'b0;
    d.scl_p = scl_s;
    d.sda_p = sda_s;
    rise = scl_s && !q.scl_p;
    fall = !scl_s && q.scl_p;
    start = scl_s && q.scl_p && q.sda_p && !sda_s;
    stop = scl_s && q.scl_p && !q.sda_p && sda_s;
    d.lockout_seen = lockout_s || (reg_low_s && q.lockout_seen);
    live = (reg_low_s && (lockout_s || q.lockout_seen)) ? FAULT_IN_REG_LOW : fault_s;
    d.live_p = live;
    push = (live != FAULT_NORMAL) && (live != q.live_p);
    case (q.ptr)
      REG_STATUS: rd_byte = {q.wd_flag, q.dog_en, stat_s, fq_empty ? live : fq_head};
      REG_CTRL: rd_byte = {1'b0, q.ctrl};
      default: rd_byte = UNMAPPED_VALUE;
    endcase
    if (q.st != S_IDLE) begin
      d.hang = q.hang + 32'h1;
    end
    hang_hit = (q.st != S_IDLE) && (q.hang == HANGUP_CYC - 32'h1);
    if (q.dog_en) begin
      d.wd = q.wd + 32'h1;
    end
    wd_hit = q.dog_en && (q.wd == WATCHDOG_CYC - 32'h1);
    case (q.st)
      S_ADDR, S_WR: begin
        if (rise) begin
          d.shift = {q.shift[6:0], sda_s};
          d.cnt = q.cnt + 3'h1;
          d.last = (q.cnt == 3'h7);
        end else if (fall && q.last) begin
          d.last = 1'b0;
          d.cnt = 3'h0;
          if (q.st == S_ADDR) begin
            if (addr_match(q.shift)) begin
              d.st = S_ADDR_ACK;
              d.sda_oe = 1'b1;
              d.rw = q.shift[0];
              d.first = 1'b1;
            end else begin
              d.st = S_SKIP;
            end
          end else begin
            d.st = S_WR_ACK;
            d.sda_oe = 1'b1;
            d.first = 1'b0;
            if (q.first) begin
              d.ptr = q.shift;
            end else begin
              wr_done = 1'b1;
              d.host = 1'b1;
              d.wd = 32'h0;
              if (q.ptr == REG_STATUS) begin
                d.dog_en = q.shift[B_DOG_EN];
              end else if (q.ptr == REG_CTRL) begin
                if (q.shift[B_CTRL_RST]) begin
                  d.ctrl = CTRL_RST;
                  d.dog_en = DOG_EN_RST;
                  d.wd_flag = 1'b0;
                end else begin
                  d.ctrl = q.shift[6:0];
                end
              end
            end
          end
        end
      end
      S_ADDR_ACK: begin
        if (fall) begin
          if (q.rw) begin
            load = 1'b1;
            d.st = S_RD;
          end else begin
            d.st = S_WR;
            d.sda_oe = 1'b0;
          end
        end
      end
      S_WR_ACK: begin
        if (fall) begin
          d.st = S_WR;
          d.sda_oe = 1'b0;
        end
      end
      S_RD: begin
        // drive data only after falling edge
        if (fall) begin
          if (q.cnt == 3'h7) begin
            d.st = S_RD_ACK;
            d.sda_oe = 1'b0;
          end else begin
            d.shift = {q.shift[6:0], 1'b0};
            d.cnt = q.cnt + 3'h1;
            d.sda_oe = !q.shift[6];
          end
        end
      end
      S_RD_ACK: begin
        if (rise) begin
          d.nack = sda_s;
        end else if (fall) begin
          if (q.nack) begin
            d.st = S_SKIP;
          end else begin
            load = 1'b1;
            d.st = S_RD;
          end
        end
      end
      S_SKIP: begin
        d.sda_oe = 1'b0;
      end
      default: begin
        d.sda_oe = 1'b0;
      end
    endcase
    pop = 1'b0;
    if (load) begin
      d.shift = rd_byte;
      d.cnt = 3'h0;
      d.sda_oe = !rd_byte[7];
      if (q.ptr == REG_STATUS) begin
        pop = !fq_empty;
        d.wd_flag = 1'b0;
      end
    end
    if (wd_hit) begin
      d.wd = 32'h0;
      d.wd_flag = 1'b1;
      d.ctrl = CTRL_RST;
      d.host = 1'b0;
    end
    if (hang_hit) begin
      d.hang = q.hang;
      d.st = S_IDLE;
      d.sda_oe = 1'b0;
      d.last = 1'b0;
    end
    if (stop) begin
      d.st = S_IDLE;
      d.sda_oe = 1'b0;
      d.last = 1'b0;
      d.hang = 32'h0;
    end
    if (start) begin
      d.st = S_ADDR;
      d.cnt = 3'h0;
      d.last = 1'b0;
      d.sda_oe = 1'b0;
      d.hang = 32'h0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
      q.ctrl <= CTRL_RST;
      q.dog_en <= DOG_EN_RST;
    end else begin
      q <= d;
    end
  end

  assign sda_out = q.sda_o;
  assign sda_oe = q.sda_oe;
  assign status_output_enable = q.ctrl[B_EN_STAT];
  assign termination_enable = q.ctrl[B_EN_TERM];
  assign charge_disable = q.ctrl[B_CE];
  assign high_impedance_standby = q.ctrl[B_HZ];
  assign input_current_limit_select = q.ctrl[LIMIT_HI:LIMIT_LO];
  assign host_mode = q.host;
  assign watchdog_expired_flag = q.wd_flag;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  addr_ack_a: assert property (
    (q.st == S_ADDR_ACK) |-> (q.sda_oe && addr_match(q.shift)))
    else $error("ack without address match");
  addr_skip_a: assert property (
    (q.st == S_ADDR && fall && q.last && !addr_match(q.shift) && !start && !stop
      && !hang_hit) |=> (q.st == S_SKIP && !q.sda_oe))
    else $error("foreign address not ignored");
  start_detect_a: assert property (
    start |=> (q.st == S_ADDR && q.cnt == 3'h0 && q.hang == 32'h0))
    else $error("start not taken");
  stop_idle_a: assert property (
    (stop && !start) |=> (q.st == S_IDLE && !q.sda_oe) [*2])
    else $error("stop did not release link");
  sda_stable_a: assert property (
    $changed(q.sda_oe) |-> (!$past(scl_s) || $past(hang_hit) || $past(stop)
      || $past(start)))
    else $error("sda changed while scl high");
  hangup_reset_a: assert property (
    (hang_hit && !start && !stop) |=> (q.st == S_IDLE && !q.sda_oe
      && q.hang == $past(q.hang)))
    else $error("hang-up did not reset engine");
  unmapped_ff_a: assert property (
    (load && q.ptr != REG_STATUS && q.ptr != REG_CTRL && !start && !stop && !hang_hit)
      |=> (q.shift == UNMAPPED_VALUE))
    else $error("unmapped read not FF");
  wd_expire_a: assert property (
    wd_hit |=> (q.wd_flag && q.ctrl == CTRL_RST && !q.host && q.wd == 32'h0))
    else $error("watchdog expiry not handled");
  ctrl_reset_a: assert property (
    (wr_done && q.ptr == REG_CTRL && q.shift[B_CTRL_RST]) |=> (q.ctrl == CTRL_RST
      && q.dog_en == DOG_EN_RST))
    else $error("register reset ignored");
  wd_restart_a: assert property (
    wr_done |=> (q.wd == 32'h0 && q.host))
    else $error("write did not restart watchdog");
  fault_pop_a: assert property (
    (load && q.ptr == REG_STATUS && !fq_empty) |-> (pop && rd_byte[3:0] == fq_head))
    else $error("queued fault not delivered");

  read_status_c: cover property (load && q.ptr == REG_STATUS);
  write_ctrl_c: cover property (wr_done && q.ptr == REG_CTRL);
  hangup_c: cover property (hang_hit);
  wd_expire_c: cover property (wd_hit);
endmodule

// ---- design/charger_pkg.sv ----
/*
  Shared constants of the charger serial slave: address, register map,
  field positions, reset values, fault codes and timing counts.
  Assumes a 50 MHz core clock.
*/
package charger_pkg;
  // slave address and register map
  localparam logic [6:0] DEV_ADDR = 7'h6A;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h01;
  localparam logic [7:0] UNMAPPED_VALUE = 8'hFF;
  // status register fields
  localparam int B_WD_FLAG = 7;
  localparam int B_DOG_EN = 6;
  // control register fields
  localparam int B_CTRL_RST = 7;
  localparam int LIMIT_HI = 6;
  localparam int LIMIT_LO = 4;
  localparam int B_EN_STAT = 3;
  localparam int B_EN_TERM = 2;
  localparam int B_CE = 1;
  localparam int B_HZ = 0;
  // reset values
  localparam logic DOG_EN_RST = 1'b0;
  localparam logic [6:0] CTRL_RST = 7'h0C;
  // fault codes
  localparam logic [3:0] FAULT_NORMAL = 4'h0;
  localparam logic [3:0] FAULT_IN_REG_LOW = 4'hA;
  // fault queue
  localparam logic [3:0] FQ_DEPTH = 4'h8;
  // timing
  localparam longint CLK_HZ = 50000000;
  localparam longint WATCHDOG_S = 50;
  localparam longint HANGUP_US = 1000;
  localparam logic [31:0] WATCHDOG_CYCLES = 32'(WATCHDOG_S * CLK_HZ);
  localparam logic [31:0] HANGUP_CYCLES = 32'(HANGUP_US * CLK_HZ / 1000000);
endpackage

// ---- design/sync2.sv ----
/*
  Two-flop synchroniser for a bundle of asynchronous levels.
  Assumes each bit is an independent level.
*/
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;
  sync_t r_q, r_d;
  always_comb begin
    r_d = r_q;
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end
  assign q = r_q.s2;
endmodule

// ---- design/fault_queue.sv ----
/*
  Small queue of pending fault codes; the head comes out of a register.
  Assumes push and pop are one-cycle strobes on the core clock.
*/
`timescale 1ns/1ps
module fault_queue
  import charger_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // fill side
  input wire logic push,
  input wire logic [3:0] push_code,
  // drain side
  input wire logic pop,
  output logic [3:0] head,
  output logic empty
);
  typedef struct packed {
    logic [7:0][3:0] mem;
    logic [2:0] wp;
    logic [2:0] rp;
    logic [3:0] count;
    logic [3:0] head;
    logic empty;
  } fq_t;
  fq_t q, d;
  logic do_pop;
  logic do_push;
  always_comb begin
    d = q;
    do_pop = pop && (q.count != 4'h0);
    do_push = push && ((q.count != FQ_DEPTH) || do_pop);
    if (do_push) begin
      d.mem[q.wp] = push_code;
      d.wp = q.wp + 3'h1;
    end
    if (do_pop) begin
      d.rp = q.rp + 3'h1;
    end
    d.count = 4'(q.count + {3'h0, do_push} - {3'h0, do_pop});
    d.head = d.mem[d.rp];
    d.empty = (d.count == 4'h0);
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.empty <= 1'b1;
    end else begin
      q <= d;
    end
  end
  assign head = q.head;
  assign empty = q.empty;
endmodule

// ---- tb/i2c_master_model.sv ----
/*
  Behavioural bus master for the charger serial slave: start, stop,
  byte out with ack sample, byte in with ack/nack.
  Assumes a pull-up on the data wire; the bench forms the wire level.
*/
`timescale 1ns/1ps
module i2c_master_model (
  // clock
  input wire logic clk,
  // link
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic q(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic start_cond();
    sda_low = 1'b0;
    q(4);
    scl = 1'b1;
    q(4);
    sda_low = 1'b1;
    q(4);
    scl = 1'b0;
  endtask
  task automatic stop_cond();
    sda_low = 1'b1;
    q(4);
    scl = 1'b1;
    q(4);
    sda_low = 1'b0;
    q(4);
  endtask
  task automatic xfer_bit(input logic b, output logic r);
    q(4);
    sda_low = !b;
    q(4);
    scl = 1'b1;
    q(4);
    r = sda;
    q(4);
    scl = 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) xfer_bit(d[i], r);
    xfer_bit(1'b1, ack_n);
  endtask
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, r);
      d[i] = r;
    end
    xfer_bit(last, r);
  endtask
endmodule

// ---- tb/charger_i2c_slave_status_control_tb.sv ----
/*
  Self-checking bench of the charger serial slave with a master model.
  Assumes shortened watchdog and hang-up counts set below.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module charger_i2c_slave_status_control_tb
  import charger_pkg::*;
();
  logic clk, rstn, scl, m_low, sda, sda_oe, ack, reg_low, lockout, dog_en, wd_flag, sda_o;
  logic stat_en, term_en, chg_dis, standby, host_mode;
  logic [1:0] charge_state;
  logic [3:0] fault_code;
  logic [2:0] cur_limit;
  logic [7:0] pins, v, p;
  logic [7:0] rb [9];
  logic [6:0] a;
  int errors, total_checks, off;
  assign sda = !(m_low | sda_oe);
  assign pins = {1'b0, cur_limit, stat_en, term_en, chg_dis, standby};
  charger_serial_slave #(.WATCHDOG_CYC(32'h3E8), .HANGUP_CYC(32'h7D0)) dut_u (
    .clk(clk), .rstn(rstn), .scl(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe(sda_oe),
    .charge_state(charge_state), .fault_code(fault_code),
    .internal_regulator_low(reg_low), .input_undervoltage_lockout(lockout),
    .input_current_limit_select(cur_limit), .status_output_enable(stat_en),
    .termination_enable(term_en), .charge_disable(chg_dis),
    .high_impedance_standby(standby), .host_mode(host_mode),
    .watchdog_expired_flag(wd_flag));
  i2c_master_model master_u (.clk(clk), .scl(scl), .sda_low(m_low), .sda(sda));
  function automatic logic [7:0] stat_exp(input logic [1:0] cs, input logic [3:0] c);
    return {1'b0, dog_en, cs, c};
  endfunction
  function automatic logic [3:0] fq_code(input int k, input int o);
    return 4'((k + o) % 10 + 1);
  endfunction
  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    master_u.start_cond();
    master_u.send_byte({DEV_ADDR, 1'b0}, ack);
    `CHK("address ack", 1'b0, ack)
    master_u.send_byte(r, ack);
    master_u.send_byte(d, ack);
    `CHK("data ack", 1'b0, ack)
    master_u.stop_cond();
  endtask
  task automatic rd(input logic [7:0] r, input int n);
    master_u.start_cond();
    master_u.send_byte({DEV_ADDR, 1'b0}, ack);
    master_u.send_byte(r, ack);
    master_u.start_cond();
    master_u.send_byte({DEV_ADDR, 1'b1}, ack);
    `CHK("read ack", 1'b0, ack)
    for (int i = 0; i < n; i++) master_u.recv_byte(i == n - 1, rb[i]);
    master_u.stop_cond();
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #1000000;
    errors++;
    report_and_stop();
  end
  initial begin
    {rstn, reg_low, lockout, dog_en, charge_state, fault_code} = '0;
    void'($urandom(73));
    master_u.q(8);
    rstn = 1'b1;
    master_u.q(4);
    `CHK("reset ctrl", 8'h0C, pins)
    `CHK("reset host mode", 1'b0, host_mode)
    `CHK("open drain level", 1'b0, sda_o)
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 7'h6B : 7'($urandom);
      if (a == DEV_ADDR) a = 7'h2A;
      master_u.start_cond();
      master_u.send_byte({a, i[0]}, ack);
      `CHK("foreign ack", 1'b1, ack)
      master_u.stop_cond();
    end
    for (int i = 0; i < 8; i++) begin
      v = {1'b0, 3'(i), 4'($urandom)};
      wr(REG_CTRL, v);
      `CHK("ctrl pins", v, pins)
      `CHK("host mode", 1'b1, host_mode)
      rd(REG_CTRL, 2);
      `CHK("ctrl read 0", v, rb[0])
      `CHK("ctrl read 1", v, rb[1])
    end
    for (int i = 0; i < 6; i++) begin
      charge_state = (i < 4) ? 2'(i) : 2'($urandom);
      {reg_low, lockout} = 2'($urandom_range(2, 0));
      rd(REG_STATUS, 1);
      `CHK("charge state", stat_exp(charge_state, 4'h0), rb[0])
      {reg_low, lockout} = 2'h0;
      master_u.q(4);
    end
    charge_state = 2'h0;
    off = int'($urandom_range(9, 0));
    for (int i = 0; i < 8; i++) begin
      fault_code = fq_code(i, off);
      master_u.q(8);
    end
    fault_code = 4'h0;
    master_u.q(8);
    rd(REG_STATUS, 9);
    for (int i = 0; i < 9; i++) begin
      `CHK("fault queue", stat_exp(2'h0, (i < 8) ? fq_code(i, off) : 4'h0), rb[i])
    end
    {reg_low, lockout} = 2'h3;
    master_u.q(8);
    lockout = 1'b0;
    master_u.q(8);
    reg_low = 1'b0;
    master_u.q(8);
    rd(REG_STATUS, 2);
    `CHK("regulator fault", stat_exp(2'h0, FAULT_IN_REG_LOW), rb[0])
    `CHK("fault drained", stat_exp(2'h0, FAULT_NORMAL), rb[1])
    for (int i = 0; i < 3; i++) begin
      p = (i == 0) ? 8'h02 : (i == 1) ? 8'hFF : 8'($urandom_range(255, 2));
      wr(p, 8'($urandom));
      rd(p, 2);
      `CHK("unmapped first read", UNMAPPED_VALUE, rb[0])
      `CHK("unmapped read", UNMAPPED_VALUE, rb[1])
    end
    wr(REG_CTRL, 8'h73);
    wr(REG_CTRL, 8'h80 | 8'($urandom));
    `CHK("ctrl soft reset", 8'h0C, pins)
    wr(REG_STATUS, 8'h80);
    `CHK("flag read only", 1'b0, wd_flag)
    v = {1'b0, 7'($urandom)};
    master_u.start_cond();
    master_u.send_byte({DEV_ADDR, 1'b0}, ack);
    master_u.send_byte(REG_CTRL, ack);
    master_u.q(1500);
    wr(REG_CTRL, v);
    `CHK("restart renews timer", v, pins)
    master_u.start_cond();
    master_u.send_byte({DEV_ADDR, 1'b0}, ack);
    master_u.q(2100);
    master_u.send_byte(REG_CTRL, ack);
    `CHK("hang-up ignore", 1'b1, ack)
    master_u.send_byte(8'h7F, ack);
    master_u.stop_cond();
    `CHK("hang-up ctrl kept", v, pins)
    wr(REG_STATUS, 8'h40);
    dog_en = 1'b1;
    wr(REG_CTRL, 8'h35);
    master_u.q(700);
    `CHK("watchdog renewed", 1'b0, wd_flag)
    master_u.q(400);
    `CHK("watchdog expired", 1'b1, wd_flag)
    `CHK("defaults reloaded", 8'h0C, pins)
    `CHK("host mode left", 1'b0, host_mode)
    rd(REG_STATUS, 1);
    `CHK("status flag bit", 1'b1, rb[0][B_WD_FLAG])
    wr(REG_CTRL, 8'h5A);
    `CHK("ctrl before reset", 8'h5A, pins)
    rstn = 1'b0;
    master_u.q(2);
    rstn = 1'b1;
    dog_en = 1'b0;
    master_u.q(4);
    `CHK("mid-run reset ctrl", 8'h0C, pins)
    `CHK("mid-run reset host", 1'b0, host_mode)
    `CHK("mid-run reset flag", 1'b0, wd_flag)
    wr(REG_STATUS, 8'h00);
    report_and_stop();
  end
endmodule
